/* File: rtl/iead_pkg.sv */
// Purpose: Shared constants and types for interrupt enable and dispatch
// Assumes: 8-bit special-function register port, one clock domain
// Notes: Offsets are byte addresses on the core's register port
package iead_pkg;
   localparam int NUM_SRC = 18;
   localparam int SRC_W = 5;
   localparam int PRIO_W = 2;
   localparam int NUM_LVL = 4;

   // Register offsets
   localparam logic [7:0] OFS_EN_C = 8'h9A;
   localparam logic [7:0] OFS_EN_A = 8'hA8;
   localparam logic [7:0] OFS_EN_B = 8'hB8;

   // Field positions and writable masks
   localparam int GLOBAL_EN_BIT = 7;
   localparam logic [7:0] MASK_EN_A = 8'hBF;
   localparam logic [7:0] MASK_EN_BC = 8'h3F;
   localparam logic [7:0] RST_EN = 8'h00;

   // Vector layout: base plus eight bytes per source number
   localparam logic [15:0] VEC_BASE = 16'h0003;
   localparam int VEC_SHIFT = 3;

   // Latency in machine cycles (one clock each)
   localparam int DETECT_CYC = 1;
   localparam int CALL_CYC = 6;
   localparam logic [2:0] CALL_LAST = 3'(CALL_CYC - 1);

   typedef enum logic [1:0] {
      IEAD_IDLE,
      IEAD_DETECT,
      IEAD_CALL
   } iead_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } iead_bus_req_t;

   typedef struct packed {
      logic call_active;
      logic call_done;
      logic [15:0] vector;
      logic [SRC_W-1:0] src;
   } iead_call_t;

   // Source number to its enable bit in a/b/c order
   function automatic logic [NUM_SRC-1:0] iead_src_en(
      input logic [7:0] a,
      input logic [7:0] b,
      input logic [7:0] c
   );
      logic [NUM_SRC-1:0] e;
      e = '0;
      e[5:0] = a[5:0];
      e[6] = c[1];
      e[7] = c[2];
      e[13:8] = b[5:0];
      e[14] = c[3];
      e[15] = c[4];
      e[16] = c[0];
      e[17] = c[5];
      return e;
   endfunction : iead_src_en
endpackage : iead_pkg

/* File: rtl/iead_arbiter.sv */
// Purpose: Pick the winning pending source
// Assumes: Requests already gated by enables
// Notes: Purely combinational; highest level wins, then lowest number
`timescale 1ns/1ps
module iead_arbiter import iead_pkg::*; #(
   parameter int N = NUM_SRC
) (
   input wire logic [N-1:0] req,
   input wire logic [N-1:0][PRIO_W-1:0] prio,
   output logic valid,
   output logic [SRC_W-1:0] win,
   output logic [PRIO_W-1:0] win_prio
);
   // Source numbers must fit the winner field
   if (N < 1 || N > (1 << SRC_W)) begin : g_bad_n
      $error("iead_arbiter: bad N");
   end

   logic [N:0][PRIO_W-1:0] best_p;
   logic [N:0][SRC_W-1:0] best_i;
   logic [N:0] best_v;

   assign best_p[0] = '0;
   assign best_i[0] = '0;
   assign best_v[0] = 1'b0;

   // Strict greater-than keeps the lower number on ties
   for (genvar i = 0; i < N; i++) begin : g_arb
      logic take;
      assign take = req[i] && (!best_v[i] || prio[i] > best_p[i]);
      assign best_v[i+1] = best_v[i] || req[i];
      assign best_p[i+1] = take ? prio[i] : best_p[i];
      assign best_i[i+1] = take ? SRC_W'(i) : best_i[i];
   end

   assign valid = best_v[N];
   assign win = best_i[N];
   assign win_prio = best_p[N];
endmodule : iead_arbiter

/* File: rtl/iead_ctrl.sv */
// Purpose: Interrupt enable registers, request flags and forced-call dispatch
// Assumes: Core pulses instr_boundary when it may accept a forced call,
//    and pulses return_from_interrupt_instr_exec when a return-from-interrupt instruction executes
// Notes: Priority levels arrive as inputs; their registers live elsewhere
//
// Functional notes
// - Bit 7 of enable register a is a global enable gating every acknowledge.
// - Register a bits 5..0 enable sleep timer, aes, serial1 rx, serial0 rx, converter, radio fifo.
// - Register b bits 5..0 enable port0, timer4, timer3, timer2, timer1, dma done.
// - Register c bits 5..0 enable watchdog, port1, serial1 tx, serial0 tx, port2, radio general.
// - A taken interrupt drives the core to the fixed vector of its source.
// - A running service is preempted only by a strictly higher priority.
// - The return instruction ends the current service level.
// - A request flag sets on its event whatever the enables say.
// - An enabled set flag is acknowledged at the next instruction boundary by a forced call.
// - A request at or below the running level stays pending until it is the highest.
// - Fastest response is one detect cycle plus six forced-call cycles.
// - Vector is 03h plus eight times the source number.
// - Hardware-cleared flags clear when the core vectors to the source.
`timescale 1ns/1ps
module iead_ctrl import iead_pkg::*; #(
   parameter logic [NUM_SRC-1:0] HW_CLEAR_MASK = '1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [NUM_SRC-1:0] src_event,
   input wire logic [NUM_SRC-1:0] flag_clr,
   input wire logic [NUM_SRC-1:0][PRIO_W-1:0] src_prio,
   input wire logic instr_boundary,
   input wire logic return_from_interrupt_instr_exec,
   output logic [NUM_SRC-1:0] flags,
   output logic call_active,
   output logic call_done,
   output logic [15:0] call_vector,
   output logic [SRC_W-1:0] call_src,
   output logic [NUM_LVL-1:0] in_service
);
   // One in-service bit per priority code
   if (NUM_LVL != (1 << PRIO_W)) begin : g_bad_lvl
      $error("iead_ctrl: level count mismatch");
   end

   typedef struct packed {
      logic [7:0] en_a;
      logic [7:0] en_b;
      logic [7:0] en_c;
      logic [NUM_SRC-1:0] flags;
      logic [NUM_LVL-1:0] in_svc;
      iead_state_t state;
      logic [2:0] cnt;
      logic [SRC_W-1:0] sel;
      logic [PRIO_W-1:0] sel_prio;
      logic done;
      logic [7:0] rdata;
      logic [15:0] vec;
   } iead_regs_t;

   iead_regs_t q_r;
   iead_regs_t q_nxt;
   iead_bus_req_t bus;
   iead_call_t call;

   logic [NUM_SRC-1:0] src_en;
   logic [NUM_SRC-1:0] gated_req;
   logic arb_valid;
   logic [SRC_W-1:0] arb_win;
   logic [PRIO_W-1:0] arb_prio;
   logic svc_any;
   logic [PRIO_W-1:0] svc_lvl;
   logic may_take;

   assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

   assign src_en = iead_src_en(q_r.en_a, q_r.en_b, q_r.en_c);
   assign gated_req = q_r.en_a[GLOBAL_EN_BIT] ? (q_r.flags & src_en) : '0;

   iead_arbiter #(
      .N(NUM_SRC)
   ) u_arb (
      .req(gated_req),
      .prio(src_prio),
      .valid(arb_valid),
      .win(arb_win),
      .win_prio(arb_prio)
   );

   // Highest level currently in service
   always_comb begin
      svc_any = |q_r.in_svc;
      svc_lvl = '0;
      for (int l = 0; l < NUM_LVL; l++) begin
         if (q_r.in_svc[l]) begin
            svc_lvl = PRIO_W'(l);
         end
      end
   end

   // Lower or equal requests simply stay pending here
   assign may_take = arb_valid && (!svc_any || arb_prio > svc_lvl);

   always_comb begin
      q_nxt = q_r;
      q_nxt.done = 1'b0;

      // Register writes; reserved bits never stored
      if (bus.wr) begin
         unique case (bus.addr)
            OFS_EN_A: begin
               q_nxt.en_a = bus.wdata & MASK_EN_A;
            end
            OFS_EN_B: begin
               q_nxt.en_b = bus.wdata & MASK_EN_BC;
            end
            OFS_EN_C: begin
               q_nxt.en_c = bus.wdata & MASK_EN_BC;
            end
            default: begin
            end
         endcase
      end

      // Read data valid the cycle after the strobe only
      q_nxt.rdata = 8'h00;
      if (bus.rd) begin
         unique case (bus.addr)
            OFS_EN_A: begin
               q_nxt.rdata = q_r.en_a;
            end
            OFS_EN_B: begin
               q_nxt.rdata = q_r.en_b;
            end
            OFS_EN_C: begin
               q_nxt.rdata = q_r.en_c;
            end
            default: begin
               q_nxt.rdata = 8'h00;
            end
         endcase
      end

      // Clear first so a same-cycle event wins
      q_nxt.flags = q_r.flags & ~flag_clr;

      // Return ends the highest active level
      if (return_from_interrupt_instr_exec) begin
         for (int l = 0; l < NUM_LVL; l++) begin
            if (PRIO_W'(l) == svc_lvl) begin
               q_nxt.in_svc[l] = 1'b0;
            end
         end
      end

      unique case (q_r.state)
         IEAD_IDLE: begin
            if (instr_boundary && may_take) begin
               q_nxt.state = IEAD_DETECT;
               q_nxt.sel = arb_win;
               q_nxt.sel_prio = arb_prio;
               q_nxt.vec = VEC_BASE + (16'(arb_win) << VEC_SHIFT);
            end
         end
         IEAD_DETECT: begin
            // Detect takes DETECT_CYC, then the call begins
            q_nxt.state = IEAD_CALL;
            q_nxt.cnt = CALL_LAST;
            if (HW_CLEAR_MASK[q_r.sel]) begin
               q_nxt.flags[q_r.sel] = 1'b0;
            end
            q_nxt.in_svc[q_r.sel_prio] = 1'b1;
         end
         IEAD_CALL: begin
            if (q_r.cnt == 3'h0) begin
               q_nxt.state = IEAD_IDLE;
               q_nxt.done = 1'b1;
            end else begin
               q_nxt.cnt = q_r.cnt - 3'h1;
            end
         end
      endcase

      // Events always set their flag, even over a hardware clear
      q_nxt.flags = q_nxt.flags | src_event;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         q_r <= '{en_a: RST_EN, en_b: RST_EN, en_c: RST_EN, flags: '0, in_svc: '0,
                  state: IEAD_IDLE, cnt: 3'h0, sel: '0, sel_prio: '0, done: 1'b0,
                  rdata: 8'h00, vec: VEC_BASE};
      end else begin
         q_r <= q_nxt;
      end
   end

   // Vector registered at selection, so it holds until the next dispatch
   always_comb begin
      call.call_active = (q_r.state == IEAD_CALL);
      call.call_done = q_r.done;
      call.src = q_r.sel;
      call.vector = q_r.vec;
   end

   assign reg_rdata = q_r.rdata;
   assign flags = q_r.flags;
   assign call_active = call.call_active;
   assign call_done = call.call_done;
   assign call_vector = call.vector;
   assign call_src = call.src;
   assign in_service = q_r.in_svc;
endmodule : iead_ctrl

/* File: verif/iead_core_model.sv */
// Purpose: Core-side model giving instruction boundaries and returns
// Assumes: Boundaries are withheld from the second forced-call cycle to one cycle after the call
// Notes: Slow mode offers a boundary every fourth cycle only
`timescale 1ns/1ps
module iead_core_model (
   input wire logic clk,
   input wire logic rst,
   input wire logic call_active,
   input wire logic slow,
   input wire logic ret_req,
   output logic instr_boundary,
   output logic return_from_interrupt_instr_exec
);
   logic [1:0] cnt_r;
   always_ff @(posedge clk) begin
      cnt_r <= rst ? 2'h0 : cnt_r + 2'h1;
      instr_boundary <= !rst && !call_active && (!slow || cnt_r == 2'h0);
      return_from_interrupt_instr_exec <= !rst && ret_req;
   end
endmodule : iead_core_model

/* File: verif/iead_ctrl_props.sv */
// Purpose: Port-level checks of enable and dispatch
// Assumes: One clock, synchronous reset
// Notes: Global enable is shadowed from register writes
`timescale 1ns/1ps
module iead_ctrl_props import iead_pkg::*; #(
   parameter logic [NUM_SRC-1:0] HW_CLEAR_MASK = '1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic [NUM_SRC-1:0] src_event,
   input wire logic [NUM_SRC-1:0][PRIO_W-1:0] src_prio,
   input wire logic return_from_interrupt_instr_exec,
   input wire logic [NUM_SRC-1:0] flags,
   input wire logic call_active,
   input wire logic call_done,
   input wire logic [15:0] call_vector,
   input wire logic [SRC_W-1:0] call_src,
   input wire logic [NUM_LVL-1:0] in_service
);
   logic ga_r;
   always_ff @(posedge clk) begin
      if (rst) ga_r <= 1'b0;
      else if (reg_wr && reg_addr == OFS_EN_A) ga_r <= reg_wdata[GLOBAL_EN_BIT];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_unused;
      $past(reg_rd) |-> (reg_rdata & 8'h40) == 8'h00 &&
         ($past(reg_addr) == OFS_EN_A || reg_rdata[7:6] == 2'h0);
   endproperty
   a_unused: assert property (p_unused) else $error("unused bits");
   property p_flag;
      |src_event |=> (flags & $past(src_event)) == $past(src_event);
   endproperty
   a_flag: assert property (p_flag) else $error("flag set");
   property p_vec;
      call_active |-> call_vector == {8'h00, call_src, 3'h3};
   endproperty
   a_vec: assert property (p_vec) else $error("vector");
   property p_len;
      $rose(call_active) |-> call_active [*6] ##1 (!call_active && call_done);
   endproperty
   a_len: assert property (p_len) else $error("call length");
   property p_global;
      $rose(call_active) |-> $past(ga_r, 2);
   endproperty
   a_global: assert property (p_global) else $error("global gate");
   property p_hwclr;
      $rose(call_active) && HW_CLEAR_MASK[call_src] && !$past(src_event[call_src])
         |-> !flags[call_src];
   endproperty
   a_hwclr: assert property (p_hwclr) else $error("hw clear");
   property p_level;
      $rose(call_active) |-> (in_service >> src_prio[call_src]) == 4'h1;
   endproperty
   a_level: assert property (p_level) else $error("level");
   // A dispatch landing on the same edge adds its own level back
   property p_return_from_interrupt_instr;
      return_from_interrupt_instr_exec && in_service != 4'h0 |=>
         $countones(in_service) ==
            $countones($past(in_service)) - 1 + int'($rose(call_active));
   endproperty
   a_return_from_interrupt_instr: assert property (p_return_from_interrupt_instr) else $error("return");
endmodule : iead_ctrl_props

/* File: verif/iead_ctrl_tb.sv */
// Purpose: Self-checking bench for enable and dispatch
// Assumes: Priorities held steady within a scenario
// Notes: Waits for no call are fixed spans, not proofs
`timescale 1ns/1ps
module iead_ctrl_tb import iead_pkg::*;;
   logic clk, rst, slow, ret_req, ib, return_from_interrupt_instr, ca, cd;
   iead_bus_req_t bus;
   logic [7:0] rdata;
   logic [NUM_SRC-1:0] ev, clr, flags;
   logic [NUM_SRC-1:0][PRIO_W-1:0] prio;
   logic [15:0] vec;
   logic [SRC_W-1:0] src;
   logic [NUM_LVL-1:0] insvc;
   int error_cnt = 0;
   int comparisons = 0;
   int cyc = 0;
   localparam int CB[NUM_SRC] = '{0, 0, 0, 0, 0, 0, 1, 2, 0, 0, 0, 0, 0, 0, 3, 4, 0, 5};
   iead_ctrl i_iead_ctrl (.clk, .rst, .reg_addr(bus.addr), .reg_wdata(bus.wdata),
      .reg_wr(bus.wr), .reg_rd(bus.rd), .reg_rdata(rdata), .src_event(ev), .flag_clr(clr),
      .src_prio(prio), .instr_boundary(ib), .return_from_interrupt_instr_exec(return_from_interrupt_instr), .flags, .call_active(ca),
      .call_done(cd), .call_vector(vec), .call_src(src), .in_service(insvc));
   iead_core_model i_iead_core_model (.clk, .rst, .call_active(ca), .slow, .ret_req,
      .instr_boundary(ib), .return_from_interrupt_instr_exec(return_from_interrupt_instr));
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task automatic finish_test;
      if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   always @(posedge clk) begin
      cyc++;
      if (cyc == 8000) begin
         error_cnt++;
         finish_test;
      end
   end
   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      comparisons++;
      if (e !== g) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
      @(posedge clk) bus.wr <= 1'b0;
   endtask : wr
   task automatic rd(logic [7:0] a, logic [7:0] e);
      @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clk) bus.rd <= 1'b0;
      #1 chk("rdata", e, rdata);
   endtask : rd
   task automatic pulse(logic [NUM_SRC-1:0] m, logic [NUM_SRC-1:0] c);
      @(posedge clk) {ev, clr} <= {m, c};
      @(posedge clk) {ev, clr} <= '0;
      #1;
   endtask : pulse
   // Every cycle, so a short call inside the span cannot slip by
   task automatic idle(int s);
      repeat (10) begin
         @(posedge clk) #1;
         chk("call_active", 0, ca);
         chk("flags", 1, flags[s]);
      end
   endtask : idle
   // Entered before the call starts; looks at its first active cycle
   task automatic take(int s);
      for (int n = 0; n < 40 && ca !== 1'b1; n++) @(posedge clk) #1;
      chk("call_active", 1, ca);
      chk("call_src", 16'(s), 16'(src));
      chk("call_vector", {8'h00, 5'(s), 3'h3}, vec);
      chk("flags", 0, flags[s]);
      chk("in_service", 1, insvc[prio[s]]);
      repeat (6) @(posedge clk);
      #1 chk("call_done", 1, cd);
      chk("call_active", 0, ca);
      repeat (2) @(posedge clk);
   endtask : take
   task automatic ret(logic [NUM_LVL-1:0] e);
      @(posedge clk) ret_req <= 1'b1;
      @(posedge clk) ret_req <= 1'b0;
      @(posedge clk) #1;
      chk("in_service", 16'(e), 16'(insvc));
      @(posedge clk);
   endtask : ret
   task automatic t_regs;
      rd(OFS_EN_A, 8'h00);
      rd(OFS_EN_B, 8'h00);
      rd(OFS_EN_C, 8'h00);
      wr(OFS_EN_A, 8'h7F);
      wr(OFS_EN_B, 8'hFF);
      wr(OFS_EN_C, 8'hFF);
      wr(8'h88, 8'hFF);
      rd(OFS_EN_A, 8'h3F);
      rd(OFS_EN_B, 8'h3F);
      rd(OFS_EN_C, 8'h3F);
      rd(8'h88, 8'h00);
   endtask : t_regs
   task automatic t_gate;
      pulse(18'h4, '0);
      idle(2);
      chk("flags", 1, flags[2]);
      pulse('0, 18'h4);
      chk("flags", 0, flags[2]);
      wr(OFS_EN_A, 8'hBF);
      rd(OFS_EN_A, 8'hBF);
      pulse(18'h4, '0);
      take(2);
      ret(4'h0);
   endtask : t_gate
   task automatic t_map;
      for (int i = 0; i < NUM_SRC; i++) begin
         wr(OFS_EN_A, i < 6 ? 8'h80 | 8'(1 << i) : 8'h80);
         wr(OFS_EN_B, (i > 7 && i < 14) ? 8'(1 << (i - 8)) : 8'h00);
         wr(OFS_EN_C, (i inside {6, 7} || i > 13) ? 8'(1 << CB[i]) : 8'h00);
         pulse('1, '0);
         take(i);
         ret(4'h0);
         pulse('0, '1);
      end
   endtask : t_map
   task automatic t_prio;
      @(posedge clk) slow <= 1'b1;
      prio[3] <= 2'h1;
      prio[5] <= 2'h1;
      prio[9] <= 2'h2;
      wr(OFS_EN_A, 8'hBF);
      wr(OFS_EN_B, 8'h3F);
      pulse(18'h28, '0);
      take(3);
      idle(5);
      pulse(18'h200, '0);
      take(9);
      ret(4'h2);
      idle(5);
      ret(4'h0);
      take(5);
      ret(4'h0);
   endtask : t_prio
   initial begin
      rst = 1'b1;
      bus = '0;
      {ev, clr, prio, slow, ret_req} = '0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_gate;
      t_map;
      t_prio;
      finish_test;
   end
endmodule : iead_ctrl_tb
bind iead_ctrl iead_ctrl_props #(.HW_CLEAR_MASK(HW_CLEAR_MASK)) i_iead_ctrl_props (.clk,
   .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .src_event, .src_prio,
   .return_from_interrupt_instr_exec, .flags, .call_active, .call_done, .call_vector, .call_src, .in_service);
